/* pmux_core.sv */
// Parameterised M-section multiplexer with shared select and optional forcing enable
`timescale 1ns/1ps
`default_nettype none

module pmux_core
   import pmux_pkg::*;
#(
   parameter int SECTIONS   = PMUX_DEF_SECTIONS,
   parameter int SEL_W      = PMUX_DEF_SEL_W,
   parameter int INPUTS     = PMUX_DEF_INPUTS,
   parameter bit HAS_ENABLE = PMUX_DEF_HAS_EN
) (
   // Clock and reset
   input  wire logic                             clk,
   input  wire logic                             sys_rst,
   // Control: clock enable and forcing enable
   input  wire pmux_ctl_t                        ctl,
   // Shared select, binary index
   input  wire logic [SEL_W-1:0]                 sel,
   // Data inputs, per section
   input  wire logic [SECTIONS-1:0][INPUTS-1:0]  data_in,
   // Section outputs
   output logic      [SECTIONS-1:0]              section_out
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   localparam int FULL_INPUTS = 1 << SEL_W;
   localparam int MIN_INPUTS  = (1 << (SEL_W - 1)) + 1;
   localparam int PIN_COUNT   = SECTIONS + SECTIONS * INPUTS + SEL_W + int'(HAS_ENABLE);
   localparam bit REDUCED     = (INPUTS < FULL_INPUTS);
   localparam logic [SEL_W:0] INPUTS_W = (SEL_W + 1)'(INPUTS);
   // Index of the top select bit alone, and a section from the middle
   localparam int MSB_INDEX   = 1 << (SEL_W - 1);
   localparam int MID_SECTION = SECTIONS / 2;

   generate
      if (SEL_W < PMUX_MIN_SEL_W) begin : g_bad_sel
         $error("pmux_core: select width below one");
      end
      if (SECTIONS < PMUX_MIN_SECTIONS || SECTIONS > PMUX_MAX_SECTIONS) begin : g_bad_sec
         $error("pmux_core: section count out of range");
      end
      if (INPUTS < MIN_INPUTS || INPUTS > FULL_INPUTS) begin : g_bad_in
         $error("pmux_core: inputs per section out of range");
      end
      if (REDUCED && HAS_ENABLE) begin : g_bad_en
         $error("pmux_core: reduced sections cannot have an enable");
      end
      if (PIN_COUNT > PMUX_PIN_LIMIT) begin : g_bad_pins
         $error("pmux_core: configuration exceeds pin limit");
      end
   endgenerate

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [SECTIONS-1:0] out;
   } pmux_state_t;

   pmux_state_t state_q;
   pmux_state_t state_d;

   // Forcing is honoured only when the enable pin is configured
   logic force_act;
   assign force_act = HAS_ENABLE && (ctl.force_high == PMUX_FORCE_ON);

   // An unknown select compares unknown, so it falls to the gap branch
   logic sel_in_range;
   assign sel_in_range = ({1'b0, sel} < INPUTS_W);

   // ----------------------------------------------------------------
   // Next-state selection
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      if (ctl.clk_en) begin
         for (int s = 0; s < SECTIONS; s++) begin
            if (force_act) begin
               state_d.out[s] = PMUX_FORCE_LEVEL;
            end else if (sel_in_range) begin
               state_d.out[s] = data_in[s][sel];
            end else begin
               // Gap or unknown select: left as don't care for synthesis
               state_d.out[s] = 1'bx;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q.out <= {SECTIONS{PMUX_OUT_RST}};
      end else begin
         state_q <= state_d;
      end
   end

   // Registered so the outputs are glitch-free; costs one cycle
   assign section_out = state_q.out;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // A normal routing cycle: enabled, not forced, select inside the section
   sequence s_route_take;
      ctl.clk_en && !force_act && sel_in_range;
   endsequence

   sequence s_force_twice;
      (ctl.clk_en && force_act) [*2];
   endsequence

   // One forcing cycle taken
   sequence s_force_take;
      ctl.clk_en && force_act;
   endsequence

   // Clock enable low, nothing taken
   sequence s_frozen;
      !ctl.clk_en;
   endsequence

   chk_route_first: assert property (
      s_route_take |=> section_out[0] == $past(data_in[0][sel]))
      else $error("first section did not follow the selected input");

   chk_route_last: assert property (
      s_route_take |=> section_out[SECTIONS-1] == $past(data_in[SECTIONS-1][sel]))
      else $error("last section did not follow the selected input");

   chk_sel_zero: assert property (
      s_route_take and (sel == '0) |=> section_out[0] == $past(data_in[0][0]))
      else $error("select zero did not route input zero");

   chk_sel_top_index: assert property (
      s_route_take and (int'(sel) == INPUTS - 1)
      |=> section_out[0] == $past(data_in[0][INPUTS-1]))
      else $error("highest select did not route highest input");

   chk_force_all_high: assert property (
      ctl.clk_en && force_act |=> section_out == {SECTIONS{PMUX_FORCE_LEVEL}})
      else $error("forcing enable did not drive all outputs high");

   chk_force_held: assert property (
      s_force_twice |=> (section_out == {SECTIONS{PMUX_FORCE_LEVEL}}) [*1] ##1 1'b1)
      else $error("outputs left high level while forcing held");

   chk_reduced_no_force: assert property (
      REDUCED && ctl.clk_en && (ctl.force_high == PMUX_FORCE_ON) && sel_in_range
      |=> section_out[0] == $past(data_in[0][sel]))
      else $error("reduced configuration reacted to the enable");

   chk_clk_en_hold: assert property (
      !ctl.clk_en |=> $stable(section_out))
      else $error("outputs changed while clock enable low");

   chk_select_drives: assert property (
      s_route_take ##1 (s_route_take and ($stable(sel) && $stable(data_in)))
      |=> $stable(section_out))
      else $error("outputs moved with select and data steady");

   // ----------------------------------------------------------------
   // Select decoding and section spread
   // ----------------------------------------------------------------
   chk_sel_one_index: assert property (
      s_route_take and (int'(sel) == 1) |=> section_out[0] == $past(data_in[0][1]))
      else $error("select one did not route input one");

   chk_sel_msb_index: assert property (
      s_route_take and (int'(sel) == MSB_INDEX)
      |=> section_out[0] == $past(data_in[0][MSB_INDEX]))
      else $error("select top bit did not route its input");

   chk_route_mid: assert property (
      s_route_take |=> section_out[MID_SECTION] == $past(data_in[MID_SECTION][sel]))
      else $error("middle section did not follow the selected input");

   chk_sel_zero_last: assert property (
      s_route_take and (sel == '0)
      |=> section_out[SECTIONS-1] == $past(data_in[SECTIONS-1][0]))
      else $error("select zero did not route input zero on the last section");

   // ----------------------------------------------------------------
   // Forcing and clock enable across cycles
   // ----------------------------------------------------------------
   chk_force_last: assert property (
      s_force_take |=> section_out[SECTIONS-1] == PMUX_FORCE_LEVEL)
      else $error("last section not forced high");

   chk_force_release: assert property (
      s_force_take ##1 s_route_take |=> section_out[0] == $past(data_in[0][sel]))
      else $error("outputs stuck high after forcing released");

   chk_freeze_force: assert property (
      s_frozen and (ctl.force_high == PMUX_FORCE_ON) |=> $stable(section_out))
      else $error("forcing enable acted while clock enable low");

   chk_freeze_route: assert property (
      s_frozen ##1 s_route_take |=> section_out[0] == $past(data_in[0][sel]))
      else $error("routing failed after a frozen cycle");

   // Latency is one cycle; a frozen cycle must keep that result
   chk_latency_one: assert property (
      s_route_take ##1 s_frozen |=> section_out[0] == $past(data_in[0][sel], 2))
      else $error("held output lost the routed value");

   chk_two_routes: assert property (
      s_route_take ##1 s_route_take |=> section_out[0] == $past(data_in[0][sel]))
      else $error("back-to-back routing lost the second selection");

   // Without an enable the forcing input must be ignored
   chk_absent_enable: assert property (
      !HAS_ENABLE && ctl.clk_en && (ctl.force_high == PMUX_FORCE_ON) && sel_in_range
      |=> section_out[SECTIONS-1] == $past(data_in[SECTIONS-1][sel]))
      else $error("forcing input acted without an enable");

endmodule

`default_nettype wire

/* pmux_pkg.sv */
// Shared constants and carrier types for the parameterised multiplexer
//
// Contract
// - Each section passes exactly one selected input.
// - Select is binary index, lowest bit least.
// - Enable at one forces every output high.
// - One to 256 sections share select, enable.
// - Total pins never exceed 800; reject larger.
// - Section inputs from 2^(N-1)+1 to 2^N.
// - Reduced sections never carry an enable.
package pmux_pkg;

   // ----------------------------------------------------------------
   // Configuration limits
   // ----------------------------------------------------------------
   localparam int PMUX_MIN_SECTIONS = 1;
   localparam int PMUX_MAX_SECTIONS = 256;
   localparam int PMUX_PIN_LIMIT    = 800;
   localparam int PMUX_MIN_SEL_W    = 1;

   // ----------------------------------------------------------------
   // Default shape: one 8-to-1 section with enable
   // ----------------------------------------------------------------
   localparam int PMUX_DEF_SECTIONS = 1;
   localparam int PMUX_DEF_SEL_W    = 3;
   localparam int PMUX_DEF_INPUTS   = 8;
   localparam bit PMUX_DEF_HAS_EN   = 1'b1;

   // ----------------------------------------------------------------
   // Levels
   // ----------------------------------------------------------------
   localparam logic PMUX_OUT_RST     = 1'b0;
   localparam logic PMUX_FORCE_LEVEL = 1'b1;
   localparam logic PMUX_FORCE_ON    = 1'b1;

   // ----------------------------------------------------------------
   // Carrier for the control group
   // ----------------------------------------------------------------
   typedef struct packed {
      logic clk_en;
      logic force_high;
   } pmux_ctl_t;

endpackage

/* pmux_src.sv */
// Data source model standing in front of the multiplexer sections
`timescale 1ns/1ps
`default_nettype none

module pmux_src #(
   parameter int W = 16
) (
   // Clock and flow control
   input  wire logic         clk,
   input  wire logic         hold,
   // Data towards the sections
   output logic [W-1:0]      data
);
   logic [15:0] state_q = 16'hACE1;

   // Moves just after the edge, so the sampling edge always sees settled data
   always @(posedge clk) begin
      if (!hold) begin
         state_q <= #1 {state_q[14:0], state_q[15] ^ state_q[13] ^ state_q[12] ^ state_q[10]};
      end
   end
   assign data = state_q[W-1:0];
endmodule

`default_nettype wire

/* tb_param_multiplexer.sv */
// Self-checking bench for the multiplexer, full and reduced shapes
`timescale 1ns/1ps
`default_nettype none

module tb_param_multiplexer;
   import pmux_pkg::*;
   localparam int SECT = 2;
   localparam int SEL     = PMUX_DEF_SEL_W;
   localparam int FULL_IN = PMUX_DEF_INPUTS;
   localparam int RED_IN  = 5;
   localparam bit HAS_EN  = PMUX_DEF_HAS_EN;
   logic                  clk = 1'b0;
   logic                  sys_rst = 1'b1;
   logic                  hold = 1'b0;
   pmux_ctl_t             ctl = '0;
   logic [SEL-1:0]        sel = '0;
   logic [16:0]           rnd = 17'h1642A;
   logic [SECT-1:0]       model = '0;
   logic                  red_model = 1'b0;
   int                    bad_count = 0;
   int                    checked = 0;
   wire  [SECT-1:0][FULL_IN-1:0] data_in;
   wire  [SECT-1:0]       section_out;
   wire                   red_out;

   pmux_src #(.W(SECT * FULL_IN)) src (.clk(clk), .hold(hold), .data(data_in));
   pmux_core #(.SECTIONS(SECT), .SEL_W(SEL), .INPUTS(FULL_IN), .HAS_ENABLE(HAS_EN)) uut (
      .clk(clk), .sys_rst(sys_rst), .ctl(ctl), .sel(sel), .data_in(data_in),
      .section_out(section_out));
   // Reduced shape: five inputs, no enable, so select 5..7 reach nothing
   pmux_core #(.SECTIONS(1), .SEL_W(SEL), .INPUTS(RED_IN), .HAS_ENABLE(1'b0)) uut_red (
      .clk(clk), .sys_rst(sys_rst), .ctl(ctl), .sel(sel), .data_in(data_in[0][RED_IN-1:0]),
      .section_out(red_out));

   initial forever #25 clk = ~clk;

   function automatic logic [16:0] lfsr(input logic [16:0] v);
      return {v[15:0], v[16] ^ v[13]};
   endfunction

   task automatic check(input string what, input logic [SECT-1:0] exp, input logic [SECT-1:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask

   // Drives one request, predicts both shapes from the inputs at the edge
   task automatic step(input pmux_ctl_t c, input logic [2:0] s);
      ctl = c;
      sel = s;
      @(posedge clk);
      if (c.clk_en) begin
         for (int i = 0; i < SECT; i++) model[i] = c.force_high ? 1'b1 : data_in[i][s];
         red_model = (s < RED_IN) ? data_in[0][s] : 1'bx;
      end
      #1;
      check("section_out", model, section_out);
      check("reduced_out", {1'b0, red_model}, {1'b0, red_out});
   endtask

   task automatic tally_and_finish;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      #2000000;
      bad_count++;
      tally_and_finish();
   end

   initial begin
      repeat (12) @(posedge clk);
      #1 sys_rst = 1'b0;
      check("reset_out", '0, section_out);
      check("reset_red", '0, {1'b0, red_out});
      hold = 1'b1;
      for (int k = 0; k < 8; k++) step(pmux_ctl_t'(2'h2), 3'(k));
      for (int k = 0; k < 8; k++) step(pmux_ctl_t'(2'h3), 3'(k));
      hold = 1'b0;
      step(pmux_ctl_t'(2'h0), 3'h6);
      step(pmux_ctl_t'(2'h2), 3'hX);
      step(pmux_ctl_t'(2'h2), 3'h1);
      for (int n = 0; n < 300; n++) begin
         rnd = lfsr(rnd);
         step(pmux_ctl_t'(rnd[1:0]), rnd[4:2]);
      end
      #10 sys_rst = 1'b1;
      #5;
      model = '0;
      red_model = 1'b0;
      check("mid_reset", '0, section_out);
      check("mid_reset_red", '0, {1'b0, red_out});
      @(posedge clk);
      #1 sys_rst = 1'b0;
      for (int k = 7; k >= 0; k--) step(pmux_ctl_t'(2'h2), 3'(k));
      tally_and_finish();
   end
endmodule

`default_nettype wire
